/* File: core/peripheral_idle_select.sv */
// Operation
// - Sixteen-bit sleep select register, read/write bits, reset zero.
// - Bits 15 and 14 read zero, writes ignored.
// - Bit 4 stored and readable, gates no module.
// - On idle with sleep enable set, selected modules gated, others active.
// - Bit 13 gates the miscellaneous glue register group.
// - Bit 12 gates the external memory interface.
// - Bit 11 gates OS tick timer, bit 10 the watchdog.
// - Bit 9 gates parallel pin port, bit 5 general-purpose port.
// - Bit 8 async serial, bit 7 I2C, bit 6 identification block.
// - Bits 3,2 sync serial 1,0; bits 1,0 timers 1,0.
// - Idle with sleep enable clear wakes all, ignores select bits.
// - Idle while asleep wakes modules whose select bit is zero.
// - Sleep enable is config bit 3; with it zero, idle leaves all active.
// - State bit 3 read-only, resets zero, one while domain asleep.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module peripheral_idle_select
    import periph_idle_pkg::*;
(
    input  wire  logic          sys_clk_in,     // Device clock, 100 MHz
    input  wire  logic          reset_n_in,     // Async reset, active low
    input  wire  logic          psel_in,        // APB select
    input  wire  logic          penable_in,     // APB access phase
    input  wire  logic          pwrite_in,      // APB write
    input  wire  logic [31:0]   paddr_in,       // APB byte address
    input  wire  logic [31:0]   pwdata_in,      // APB write data
    input  wire  logic [3:0]    pstrb_in,       // APB byte strobes
    input  wire  logic          idle_exec_in,   // Idle instruction executes, one-cycle pulse
    output logic                pready_out,     // APB ready
    output logic [31:0]         prdata_out,     // APB read data
    output logic                pslverr_out,    // APB error on unmapped address
    output module_gates_t       gates_out       // Per-module disable, high = gated
);

    // ==========================================================
    // Register state
    // ==========================================================
    logic [15:0]    select_q;
    logic [15:0]    select_d;
    logic           sleep_enable_q;
    logic           sleep_enable_d;
    logic [15:0]    gated_q;
    logic [15:0]    gated_d;
    domain_state_t  state_q;
    domain_state_t  state_d;
    logic           pready_q;
    logic [31:0]    prdata_q;
    logic           pslverr_q;

    // ==========================================================
    // APB decode
    // ==========================================================
    wire            setup_w      = psel_in && !penable_in;
    wire            access_w     = psel_in && penable_in && pready_q;
    wire            hit_select_w = (paddr_in == SLEEP_SELECT_ADDR);
    wire            hit_config_w = (paddr_in == IDLE_CONFIG_ADDR);
    wire            hit_state_w  = (paddr_in == IDLE_STATE_ADDR);
    wire            mapped_w     = hit_select_w || hit_config_w || hit_state_w;
    wire            wr_w         = access_w && pwrite_in;
    wire [15:0]     lane_mask_w  = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    wire            asleep_w     = (state_q == ST_ASLEEP);

    function automatic logic [15:0] merge_field(input logic [15:0] old_v, input logic [15:0] new_v,
                                                input logic [15:0] mask_v);
        merge_field = (old_v & ~mask_v) | (new_v & mask_v);
    endfunction

    // select register write, reserved top bits masked
    assign select_d = (wr_w && hit_select_w)
                    ? merge_field(select_q, pwdata_in[15:0], lane_mask_w & SELECT_WRITE_MASK)
                    : select_q;

    // sleep enable lives in the config register
    assign sleep_enable_d = (wr_w && hit_config_w && pstrb_in[0]) ? pwdata_in[SLEEP_ENABLE_BIT]
                                                                   : sleep_enable_q;

    // ==========================================================
    // Idle instruction handling
    // ==========================================================
    // gating changes only on the idle pulse
    always_comb
    begin
        state_d = state_q;
        gated_d = gated_q;
        if (idle_exec_in)
        begin
            if (sleep_enable_q)
            begin
                state_d = ST_ASLEEP;
                gated_d = select_q & SELECT_GATE_MASK;
            end
            else
            begin
                state_d = ST_ACTIVE;
                gated_d = SELECT_RESET;
            end
        end
        case (state_d)
            ST_ACTIVE: gated_d = SELECT_RESET;
            ST_ASLEEP: gated_d = gated_d;
            default:   gated_d = SELECT_RESET;
        endcase
    end

    wire [31:0] rd_mux_w = hit_select_w ? {16'h0000, select_q & SELECT_WRITE_MASK}
                         : hit_config_w ? {28'h000_0000, sleep_enable_q, 3'b000}
                         : hit_state_w  ? {28'h000_0000, asleep_w, 3'b000}
                         : 32'h0000_0000;

    // ==========================================================
    // Flip-flops
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            select_q       <= SELECT_RESET;
            sleep_enable_q <= 1'b0;
            gated_q        <= SELECT_RESET;
            state_q        <= ST_ACTIVE;
        end
        else
        begin
            select_q       <= select_d;
            sleep_enable_q <= sleep_enable_d;
            gated_q        <= gated_d;
            state_q        <= state_d;
        end
    end

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup_w;
            prdata_q  <= (setup_w && !pwrite_in) ? rd_mux_w : prdata_q;
            pslverr_q <= setup_w && !mapped_w;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pready_out  = pready_q;
    assign prdata_out  = prdata_q;
    assign pslverr_out = pslverr_q;

    assign gates_out = '{misc_gate:              gated_q[MISC_BIT],
                         ext_memory_gate:        gated_q[EXT_MEMORY_BIT],
                         os_tick_timer_gate:     gated_q[OS_TICK_BIT],
                         watchdog_gate:          gated_q[WATCHDOG_BIT],
                         parallel_pin_port_gate: gated_q[PARALLEL_PORT_BIT],
                         serial_async_gate:      gated_q[SERIAL_ASYNC_BIT],
                         i2c_gate:               gated_q[I2C_BIT],
                         chip_code_block_gate:   gated_q[CHIP_CODE_BIT],
                         gp_pin_port_gate:       gated_q[GP_PORT_BIT],
                         sync_serial1_gate:      gated_q[SYNC_SERIAL1_BIT],
                         sync_serial0_gate:      gated_q[SYNC_SERIAL0_BIT],
                         timer1_gate:            gated_q[TIMER1_BIT],
                         timer0_gate:            gated_q[TIMER0_BIT]};

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_idle_on;
        idle_exec_in && sleep_enable_q;
    endsequence

    sequence s_idle_off;
        idle_exec_in && !sleep_enable_q;
    endsequence

    sequence s_read_select;
        setup_w && !pwrite_in && hit_select_w ##1 access_w;
    endsequence

    sequence s_read_state;
        setup_w && !pwrite_in && hit_state_w ##1 access_w;
    endsequence

    property p_reserved_zero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        select_q[15:14] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved select bits nonzero");

    property p_write_select;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && hit_select_w && pstrb_in == 4'hf) |=> select_q == (($past(pwdata_in[15:0])) & 16'h3fff);
    endproperty
    a_write_select: assert property (p_write_select) else $error("Select write not stored");

    property p_bit4_stored;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && hit_select_w && pstrb_in[0]) |=> select_q[4] == $past(pwdata_in[4]);
    endproperty
    a_bit4_stored: assert property (p_bit4_stored) else $error("Bit 4 not stored");

    property p_sleep_gates;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gated_q == ($past(select_q) & 16'h3fef) && asleep_w;
    endproperty
    a_sleep_gates: assert property (p_sleep_gates) else $error("Selected modules not gated");

    property p_misc_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on ##1 1'b1 |-> gates_out.misc_gate == $past(select_q[13]);
    endproperty
    a_misc_gate: assert property (p_misc_gate) else $error("Misc gate wrong");

    property p_ext_memory_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.ext_memory_gate == $past(select_q[12]);
    endproperty
    a_ext_memory_gate: assert property (p_ext_memory_gate) else $error("Memory gate wrong");

    property p_os_tick_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.os_tick_timer_gate == $past(select_q[11]);
    endproperty
    a_os_tick_gate: assert property (p_os_tick_gate) else $error("Tick timer gate wrong");

    property p_parallel_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.parallel_pin_port_gate == $past(select_q[9]);
    endproperty
    a_parallel_gate: assert property (p_parallel_gate) else $error("Parallel port gate wrong");

    property p_gp_port_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.gp_pin_port_gate == $past(select_q[5]);
    endproperty
    a_gp_port_gate: assert property (p_gp_port_gate) else $error("General port gate wrong");

    property p_serial_async_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.serial_async_gate == $past(select_q[8]);
    endproperty
    a_serial_async_gate: assert property (p_serial_async_gate) else $error("Async serial gate wrong");

    property p_i2c_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.i2c_gate == $past(select_q[7]);
    endproperty
    a_i2c_gate: assert property (p_i2c_gate) else $error("I2C gate wrong");

    property p_chip_code_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.chip_code_block_gate == $past(select_q[6]);
    endproperty
    a_chip_code_gate: assert property (p_chip_code_gate) else $error("Identification gate wrong");

    property p_sync_serial_gates;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.sync_serial1_gate == $past(select_q[3]) &&
                      gates_out.sync_serial0_gate == $past(select_q[2]);
    endproperty
    a_sync_serial_gates: assert property (p_sync_serial_gates) else $error("Sync serial gate wrong");

    property p_timer1_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.timer1_gate == $past(select_q[1]);
    endproperty
    a_timer1_gate: assert property (p_timer1_gate) else $error("Timer 1 gate wrong");

    property p_timer0_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_on |=> gates_out.timer0_gate == $past(select_q[0]) &&
                      gates_out.watchdog_gate == $past(select_q[10]);
    endproperty
    a_timer0_gate: assert property (p_timer0_gate) else $error("Timer or watchdog gate wrong");

    property p_wake_all;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_idle_off |=> gated_q == 16'h0000 && !asleep_w;
    endproperty
    a_wake_all: assert property (p_wake_all) else $error("Wake did not release all");

    property p_wake_zero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (asleep_w and s_idle_on) |=> (gated_q & ~$past(select_q)) == 16'h0000;
    endproperty
    a_wake_zero: assert property (p_wake_zero) else $error("Unselected module stays gated");

    property p_hold;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        !idle_exec_in |=> $stable(gated_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Gates changed without idle");

    property p_state_bit;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (gated_q != 16'h0000) |-> asleep_w;
    endproperty
    a_state_bit: assert property (p_state_bit) else $error("State bit inconsistent");

    property p_bit4_no_gate;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        gated_q[4] == 1'b0;
    endproperty
    a_bit4_no_gate: assert property (p_bit4_no_gate) else $error("Bit 4 gates a module");

    property p_read_select;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_read_select |-> prdata_out == {16'h0000, $past(select_q)};
    endproperty
    a_read_select: assert property (p_read_select) else $error("Select read wrong");

    property p_read_state;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_read_state |-> prdata_out == {28'h000_0000, $past(asleep_w), 3'b000};
    endproperty
    a_read_state: assert property (p_read_state) else $error("State read wrong");

    property p_state_ro;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && hit_state_w && !idle_exec_in) |=> state_q == $past(state_q);
    endproperty
    a_state_ro: assert property (p_state_ro) else $error("State register written");

    property p_config_write;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && hit_config_w && pstrb_in[0]) |=> sleep_enable_q == $past(pwdata_in[SLEEP_ENABLE_BIT]);
    endproperty
    a_config_write: assert property (p_config_write) else $error("Sleep enable not stored");

    property p_select_no_wake;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && hit_select_w && !idle_exec_in) |=> gated_q == $past(gated_q) && state_q == $past(state_q);
    endproperty
    a_select_no_wake: assert property (p_select_no_wake) else $error("Select write moved gates");

    property p_slverr;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (setup_w && !mapped_w) |=> pslverr_out && pready_out;
    endproperty
    a_slverr: assert property (p_slverr) else $error("Unmapped access not flagged");

    property p_unmapped_write;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_w && !mapped_w) |=> select_q == $past(select_q) && sleep_enable_q == $past(sleep_enable_q);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write landed");

endmodule

`default_nettype wire

/* File: core/periph_idle_pkg.sv */
package periph_idle_pkg;

    // ==========================================================
    // Register map (offsets are word indices)
    // ==========================================================
    localparam int unsigned       SLEEP_SELECT_INDEX = 32'h0000_9400;
    localparam int unsigned       IDLE_CONFIG_INDEX  = 32'h0000_9404;
    localparam int unsigned       IDLE_STATE_INDEX   = 32'h0000_9405;
    localparam logic [31:0]       SLEEP_SELECT_ADDR  = 32'(SLEEP_SELECT_INDEX * 4);
    localparam logic [31:0]       IDLE_CONFIG_ADDR   = 32'(IDLE_CONFIG_INDEX * 4);
    localparam logic [31:0]       IDLE_STATE_ADDR    = 32'(IDLE_STATE_INDEX * 4);

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int unsigned       REG_WIDTH          = 16;
    localparam logic [15:0]       SELECT_WRITE_MASK  = 16'h3fff;
    localparam logic [15:0]       SELECT_GATE_MASK   = 16'h3fef;
    localparam logic [15:0]       SELECT_RESET       = 16'h0000;
    localparam int unsigned       SLEEP_ENABLE_BIT   = 3;
    localparam int unsigned       SLEEP_STATE_BIT    = 3;
    localparam int unsigned       MISC_BIT           = 13;
    localparam int unsigned       EXT_MEMORY_BIT     = 12;
    localparam int unsigned       OS_TICK_BIT        = 11;
    localparam int unsigned       WATCHDOG_BIT       = 10;
    localparam int unsigned       PARALLEL_PORT_BIT  = 9;
    localparam int unsigned       SERIAL_ASYNC_BIT   = 8;
    localparam int unsigned       I2C_BIT            = 7;
    localparam int unsigned       CHIP_CODE_BIT      = 6;
    localparam int unsigned       GP_PORT_BIT        = 5;
    localparam int unsigned       SYNC_SERIAL1_BIT   = 3;
    localparam int unsigned       SYNC_SERIAL0_BIT   = 2;
    localparam int unsigned       TIMER1_BIT         = 1;
    localparam int unsigned       TIMER0_BIT         = 0;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic misc_gate;
        logic ext_memory_gate;
        logic os_tick_timer_gate;
        logic watchdog_gate;
        logic parallel_pin_port_gate;
        logic serial_async_gate;
        logic i2c_gate;
        logic chip_code_block_gate;
        logic gp_pin_port_gate;
        logic sync_serial1_gate;
        logic sync_serial0_gate;
        logic timer1_gate;
        logic timer0_gate;
    } module_gates_t;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_ASLEEP
    } domain_state_t;

endpackage

/* File: testbench/periph_gate_model.sv */
`timescale 1ns/1ps
`default_nettype none

module periph_gate_model
    import periph_idle_pkg::*;
(
    input  wire logic          sys_clk_in,   // Device clock
    input  wire logic          reset_n_in,   // Async reset, active low
    input  wire logic          idle_exec_in, // Idle pulse from the core
    input  wire module_gates_t gates_in,     // Disable requests, high = off
    output logic [12:0]        awake_out,    // Modules still running
    output logic               stray_out     // Gate moved without idle
);
    logic          idle_q;
    module_gates_t gates_q;

    assign awake_out = ~gates_in;

    // ==========================================================
    // Gate movement watch
    // ==========================================================
    // only idle moves gates
    always @(posedge sys_clk_in)
    begin
        idle_q  <= idle_exec_in;
        gates_q <= gates_in;
        if (reset_n_in && idle_q === 1'b0 && gates_in !== gates_q)
            stray_out <= 1'b1;
        else if (stray_out !== 1'b1)
            stray_out <= 1'b0;
    end
endmodule

`default_nettype wire

/* File: testbench/test_peripheral_idle_select.sv */
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_idle_select;
    import periph_idle_pkg::*;

    logic          sys_clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, idle_exec, stray;
    logic [31:0]   paddr, pwdata, prdata, rdv;
    logic [3:0]    pstrb;
    logic [12:0]   awake;
    logic          errv;
    module_gates_t gates;
    int            errors, n_compared;

    peripheral_idle_select DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .idle_exec_in(idle_exec), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .gates_out(gates));
    periph_gate_model partner (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .idle_exec_in(idle_exec),
        .gates_in(gates), .awake_out(awake), .stray_out(stray));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d n_compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Waits on pready; slave latency is not assumed
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_in);
        end
        while (pready !== 1'b1);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle_pulse();
        @(posedge sys_clk_in);
        idle_exec <= 1'b1;
        @(posedge sys_clk_in);
        idle_exec <= 1'b0;
        #1;
    endtask

    function automatic logic [12:0] gmap(input logic [15:0] s);
        return {s[13:5], s[3:0]};
    endfunction

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        apb(1'b0, SLEEP_SELECT_ADDR, 32'h0000_0000);
        check("select", rdv, 32'h0000_0000);
        apb(1'b0, IDLE_STATE_ADDR, 32'h0000_0000);
        check("state", rdv, 32'h0000_0000);
        apb(1'b0, IDLE_CONFIG_ADDR, 32'h0000_0000);
        check("config", rdv, 32'h0000_0000);
    endtask

    task automatic t_regs();
        apb(1'b1, SLEEP_SELECT_ADDR, 32'hffff_ffff);
        apb(1'b0, SLEEP_SELECT_ADDR, 32'h0000_0000);
        check("select", rdv, 32'h0000_3fff);
        apb(1'b1, IDLE_STATE_ADDR, 32'h0000_0008);
        apb(1'b0, IDLE_STATE_ADDR, 32'h0000_0000);
        check("state ro", rdv, 32'h0000_0000);
        apb(1'b1, 32'h0000_0100, 32'h0000_ffff);
        check("slverr", 32'(errv), 32'h0000_0001);
        check("gates", 32'(gates), 32'h0000_0000);
    endtask

    task automatic t_each_bit();
        apb(1'b1, IDLE_CONFIG_ADDR, 32'h0000_0008);
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, SLEEP_SELECT_ADDR, 32'h0000_0001 << i);
            idle_pulse();
            check("gates", 32'(gates), 32'(gmap(16'h0001 << i)));
            check("awake", 32'(awake), 32'(gmap(16'h0001 << i) ^ 13'h1fff));
            apb(1'b0, IDLE_STATE_ADDR, 32'h0000_0000);
            check("state", rdv, 32'h0000_0008);
        end
    endtask

    task automatic t_wake();
        apb(1'b1, SLEEP_SELECT_ADDR, 32'h0000_3fff);
        idle_pulse();
        check("gates", 32'(gates), 32'(gmap(16'h3fff)));
        apb(1'b1, SLEEP_SELECT_ADDR, 32'h0000_0f00);
        check("gates", 32'(gates), 32'(gmap(16'h3fff)));
        idle_pulse();
        check("gates", 32'(gates), 32'(gmap(16'h0f00)));
    endtask

    task automatic t_all_wake();
        apb(1'b1, IDLE_CONFIG_ADDR, 32'h0000_0000);
        idle_pulse();
        check("gates", 32'(gates), 32'h0000_0000);
        apb(1'b0, IDLE_STATE_ADDR, 32'h0000_0000);
        check("state", rdv, 32'h0000_0000);
        check("stray", 32'(stray), 32'h0000_0000);
    endtask

    // Mid-run reset drops every gate at once
    task automatic t_midreset();
        apb(1'b1, IDLE_CONFIG_ADDR, 32'h0000_0008);
        apb(1'b1, SLEEP_SELECT_ADDR, 32'h0000_0003);
        idle_pulse();
        check("gates", 32'(gates), 32'(gmap(16'h0003)));
        @(posedge sys_clk_in);
        reset_n_in <= 1'b0;
        #1;
        check("gates", 32'(gates), 32'h0000_0000);
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        apb(1'b0, SLEEP_SELECT_ADDR, 32'h0000_0000);
        check("select", rdv, 32'h0000_0000);
        apb(1'b0, IDLE_CONFIG_ADDR, 32'h0000_0000);
        check("config", rdv, 32'h0000_0000);
        idle_pulse();
        check("gates", 32'(gates), 32'h0000_0000);
        check("stray", 32'(stray), 32'h0000_0000);
    endtask

    // ==========================================================
    // Clock, reset, sequence
    // ==========================================================
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        stop_test();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        reset_n_in = 1'b0;
        {psel, penable, pwrite, idle_exec} = 4'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_regs();
        t_each_bit();
        t_wake();
        t_all_wake();
        t_midreset();
        stop_test();
    end
endmodule

`default_nettype wire
